// ===== mil_checker_sva.sv
// Port assertions for the interrupt request logic
`timescale 1ns/1ps
module mil_checker #(
  parameter PC_WIDTH = 13
) (
  input wire                i_clock,
  input wire                i_reset,
  input wire                i_wb_cyc,
  input wire                i_wb_stb,
  input wire [31:0]         o_wb_dat,
  input wire                o_wb_ack,
  input wire [1:0]          o_quarter_phase,
  input wire                o_irq_request,
  input wire                o_stack_push,
  input wire                o_vector_load,
  input wire [PC_WIDTH-1:0] o_vector_addr,
  input wire [7:0]          o_timer_option
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  sequence svc_start_s;
    $rose(o_irq_request);
  endsequence
  sequence svc_jump_s;
    o_stack_push && o_vector_load && o_vector_addr == 13'h0004;
  endsequence
  ack_one_cycle_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");
  ack_follows_req_a: assert property (
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("request not answered next cycle");
  idle_data_zero_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
    else $error("read data not zero outside ack");
  phase_steps_a: assert property (1'b1 |=>
    o_quarter_phase == $past(o_quarter_phase) + 2'h1)
    else $error("quarter phase skipped");
  req_at_q1_a: assert property (
    $changed(o_irq_request) && !$past(i_reset) |->
    $past(o_quarter_phase) == 2'h0)
    else $error("request changed off the first quarter");
  service_jump_a: assert property (svc_start_s |-> ##[7:9] svc_jump_s)
    else $error("no vector load after request");
  push_pulse_a: assert property (o_stack_push |-> o_vector_load ##1
    !o_stack_push && !o_vector_load)
    else $error("push and vector not a paired pulse");
  option_reset_a: assert property ($past(i_reset) |->
    o_timer_option == 8'hFF)
    else $error("option register not all ones after reset");
endmodule // mil_checker

// ===== mil_core_model.sv
// Core-side model: supplies return address, leaves the service routine
`timescale 1ns/1ps
module mil_core_model #(
  parameter int EXIT_DELAY = 16
) (
  input  wire logic   i_clock,
  input  wire logic   i_reset,
  input  wire logic   i_vector_load,
  output logic        o_return_from_irq_instr,
  output logic [12:0] o_return_pc
);
  int cnt;
  // Delay gives the routine time to clear its flag before re-enabling
  always @(posedge i_clock) begin
    if (i_reset) begin
      cnt <= 0;
      o_return_from_irq_instr <= 1'b0;
      o_return_pc <= 13'h0123;
    end else begin
      o_return_from_irq_instr <= (cnt == 1);
      if (i_vector_load) cnt <= EXIT_DELAY;
      else if (cnt != 0) cnt <= cnt - 1;
      if (o_return_from_irq_instr) o_return_pc <= o_return_pc + 13'h0011;
    end
  end
endmodule // mil_core_model

// ===== mil_defines.vh
// Constants for the microcontroller interrupt request logic
`ifndef MIL_DEFINES_VH
`define MIL_DEFINES_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define MIL_IDX_CTRL_LO        8'h0B
`define MIL_IDX_CTRL_HI        8'h8B
`define MIL_IDX_PERIPH_FLAGS   8'h0C
`define MIL_IDX_TIMER_OPTION   8'h81
`define MIL_IDX_PERIPH_ENABLES 8'h8C
`define MIL_IDX_PIN_SELECT     8'h96
`define MIL_IDX_CORE_STATUS    8'hA0

// ****************************************************************
// Interrupt control bit positions
// ****************************************************************
`define MIL_GLOBAL_IRQ_ENABLE       7
`define MIL_PERIPHERAL_IRQ_ENABLE   6
`define MIL_TIMER_ZERO_OVF_ENABLE   5
`define MIL_EXT_PIN_IRQ_ENABLE      4
`define MIL_PORT_CHANGE_ENABLE      3
`define MIL_TIMER_ZERO_OVF_FLAG     2
`define MIL_EXT_PIN_IRQ_FLAG        1
`define MIL_PORT_CHANGE_FLAG        0

// ****************************************************************
// Peripheral flag and enable bit positions
// ****************************************************************
`define MIL_DATA_WRITE_DONE    7
`define MIL_CONVERSION_DONE    6
`define MIL_COMPARATOR_CHANGE  3
`define MIL_TIMER_ONE_OVF      0
`define MIL_PERIPH_IMPL_MASK   8'hC9

// ****************************************************************
// Option register
// ****************************************************************
`define MIL_EXT_EDGE_SELECT    6

// ****************************************************************
// Reset values
// ****************************************************************
`define MIL_RST_CTRL           8'h00
`define MIL_RST_PERIPH_FLAGS   8'h00
`define MIL_RST_PERIPH_ENABLES 8'h00
`define MIL_RST_TIMER_OPTION   8'hFF
`define MIL_RST_PIN_SELECT     6'h00

// ****************************************************************
// Timing and vector
// ****************************************************************
`define MIL_QUARTERS_PER_CYCLE 4
`define MIL_PHASE_Q1           2'h0
`define MIL_PHASE_Q4           2'h3
`define MIL_SERVICE_CYCLES     2'h2
`define MIL_IRQ_VECTOR         13'h0004

`endif

// ===== mil_interrupt_logic.v
// Interrupt request logic with classic Wishbone register access
`timescale 1ns/1ps
`include "mil_defines.vh"

module mil_interrupt_logic #(
  parameter PORT_WIDTH = 6,
  parameter PC_WIDTH   = 13
) (
  input  wire                  i_clock,
  input  wire                  i_reset,
  // Wishbone classic slave
  input  wire                  i_wb_cyc,
  input  wire                  i_wb_stb,
  input  wire                  i_wb_we,
  input  wire [9:2]            i_wb_adr,
  input  wire [3:0]            i_wb_sel,
  input  wire [31:0]           i_wb_dat,
  output wire [31:0]           o_wb_dat,
  output wire                  o_wb_ack,
  // Pins, asynchronous to the clock
  input  wire                  i_external_irq_pin,
  input  wire [PORT_WIDTH-1:0] i_port_pins,
  // Same-clock event pulses from peripherals and core
  input  wire                  i_timer_zero_rollover,
  input  wire                  i_conversion_done,
  input  wire                  i_data_write_done,
  input  wire                  i_comparator_change,
  input  wire                  i_timer_one_ovf,
  input  wire                  i_port_read,
  input  wire                  i_return_from_irq_instr,
  input  wire [PC_WIDTH-1:0]   i_return_pc,
  // Toward the core
  output reg  [1:0]            o_quarter_phase,
  output reg                   o_irq_request,
  output reg                   o_wake,
  output reg                   o_stack_push,
  output reg  [PC_WIDTH-1:0]   o_stack_data,
  output reg                   o_vector_load,
  output reg  [PC_WIDTH-1:0]   o_vector_addr,
  output reg  [7:0]            o_timer_option
);

  // ****************************************************************
  // Quarter phase divider
  // ****************************************************************
  wire at_q1 = (o_quarter_phase == `MIL_PHASE_Q1);
  wire at_q4 = (o_quarter_phase == `MIL_PHASE_Q4);

  always @(posedge i_clock) begin
    if (i_reset) begin
      o_quarter_phase <= `MIL_PHASE_Q1;
    end else begin
      o_quarter_phase <= o_quarter_phase + 2'h1;
    end
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  reg                  ext_meta_reg;
  reg                  ext_sync_reg;
  reg                  ext_prev_reg;
  reg [PORT_WIDTH-1:0] port_meta_reg;
  reg [PORT_WIDTH-1:0] port_sync_reg;
  reg [PORT_WIDTH-1:0] port_latch_reg;

  always @(posedge i_clock) begin
    if (i_reset) begin
      ext_meta_reg  <= 1'b0;
      ext_sync_reg  <= 1'b0;
      ext_prev_reg  <= 1'b0;
      port_meta_reg <= {PORT_WIDTH{1'b0}};
      port_sync_reg <= {PORT_WIDTH{1'b0}};
    end else begin
      ext_meta_reg  <= i_external_irq_pin;
      ext_sync_reg  <= ext_meta_reg;
      ext_prev_reg  <= ext_sync_reg;
      port_meta_reg <= i_port_pins;
      port_sync_reg <= port_meta_reg;
    end
  end

  // ****************************************************************
  // Register state and bus decode
  // ****************************************************************
  reg  [7:0]            ctrl_reg;
  reg  [7:0]            periph_flags_reg;
  reg  [7:0]            periph_enables_reg;
  reg  [PORT_WIDTH-1:0] pin_select_reg;
  reg                   ack_reg;
  reg  [31:0]           rdata_reg;
  reg  [31:0]           rdata_next;
  reg                   ext_edge_pending_reg;

  wire bus_req  = i_wb_cyc & i_wb_stb & ~ack_reg;
  wire wr_low   = bus_req & i_wb_we & i_wb_sel[0];
  wire [7:0] wd = i_wb_dat[7:0];

  wire sel_ctrl = (i_wb_adr == `MIL_IDX_CTRL_LO) |
                  (i_wb_adr == `MIL_IDX_CTRL_HI);
  wire wr_ctrl   = wr_low & sel_ctrl;
  wire wr_pflags = wr_low & (i_wb_adr == `MIL_IDX_PERIPH_FLAGS);
  wire wr_pen    = wr_low & (i_wb_adr == `MIL_IDX_PERIPH_ENABLES);
  wire wr_opt    = wr_low & (i_wb_adr == `MIL_IDX_TIMER_OPTION);
  wire wr_pinsel = wr_low & (i_wb_adr == `MIL_IDX_PIN_SELECT);

  // ****************************************************************
  // Event detection
  // ****************************************************************
  wire rising_edge  = ext_sync_reg & ~ext_prev_reg;
  wire falling_edge = ~ext_sync_reg & ext_prev_reg;
  wire valid_edge   = o_timer_option[`MIL_EXT_EDGE_SELECT] ?
                      rising_edge : falling_edge;
  // Pin flag may only be set in the Q4 to Q1 span
  wire ext_set_window = at_q4 | at_q1;
  wire ext_event = (valid_edge | ext_edge_pending_reg) & ext_set_window;

  // The latch follows the port on each read; a change landing on the
  // read cycle itself still sets the flag as the latch takes it in.
  wire port_change =
    |((port_sync_reg ^ port_latch_reg) & pin_select_reg);

  always @(posedge i_clock) begin
    if (i_reset) begin
      ext_edge_pending_reg <= 1'b0;
      port_latch_reg       <= {PORT_WIDTH{1'b0}};
    end else begin
      if (ext_set_window) begin
        ext_edge_pending_reg <= 1'b0;
      end else if (valid_edge) begin
        ext_edge_pending_reg <= 1'b1;
      end
      if (i_port_read) begin
        port_latch_reg <= port_sync_reg;
      end
    end
  end

  // ****************************************************************
  // Control register: set beats a software clear in the same cycle
  // ****************************************************************
  reg        service_start;
  reg [7:0]  ctrl_next;

  always @* begin
    ctrl_next = wr_ctrl ? wd : ctrl_reg;
    // Flags set regardless of enables
    if (ext_event) begin
      ctrl_next[`MIL_EXT_PIN_IRQ_FLAG] = 1'b1;
    end
    if (i_timer_zero_rollover) begin
      ctrl_next[`MIL_TIMER_ZERO_OVF_FLAG] = 1'b1;
    end
    if (port_change) begin
      ctrl_next[`MIL_PORT_CHANGE_FLAG] = 1'b1;
    end
    if (i_return_from_irq_instr) begin
      ctrl_next[`MIL_GLOBAL_IRQ_ENABLE] = 1'b1;
    end
    if (service_start) begin
      ctrl_next[`MIL_GLOBAL_IRQ_ENABLE] = 1'b0;
    end
  end

  // ****************************************************************
  // Peripheral flags
  // ****************************************************************
  reg [7:0] pflags_next;

  always @* begin
    pflags_next = wr_pflags ? wd : periph_flags_reg;
    if (i_data_write_done) begin
      pflags_next[`MIL_DATA_WRITE_DONE] = 1'b1;
    end
    if (i_conversion_done) begin
      pflags_next[`MIL_CONVERSION_DONE] = 1'b1;
    end
    if (i_comparator_change) begin
      pflags_next[`MIL_COMPARATOR_CHANGE] = 1'b1;
    end
    if (i_timer_one_ovf) begin
      pflags_next[`MIL_TIMER_ONE_OVF] = 1'b1;
    end
    pflags_next = pflags_next & `MIL_PERIPH_IMPL_MASK;
  end

  always @(posedge i_clock) begin
    if (i_reset) begin
      ctrl_reg           <= `MIL_RST_CTRL;
      periph_flags_reg   <= `MIL_RST_PERIPH_FLAGS;
      periph_enables_reg <= `MIL_RST_PERIPH_ENABLES;
      o_timer_option     <= `MIL_RST_TIMER_OPTION;
      pin_select_reg     <= `MIL_RST_PIN_SELECT;
    end else begin
      ctrl_reg         <= ctrl_next;
      periph_flags_reg <= pflags_next;
      if (wr_pen) begin
        periph_enables_reg <= wd & `MIL_PERIPH_IMPL_MASK;
      end
      if (wr_opt) begin
        o_timer_option <= wd;
      end
      if (wr_pinsel) begin
        pin_select_reg <= wd[PORT_WIDTH-1:0];
      end
    end
  end

  // ****************************************************************
  // Request combination
  // ****************************************************************
  wire periph_any = |(periph_flags_reg & periph_enables_reg) &
                    ctrl_reg[`MIL_PERIPHERAL_IRQ_ENABLE];
  wire ext_req  = ctrl_reg[`MIL_EXT_PIN_IRQ_FLAG] &
                  ctrl_reg[`MIL_EXT_PIN_IRQ_ENABLE];
  wire timer_zero_count_req = ctrl_reg[`MIL_TIMER_ZERO_OVF_FLAG] &
                  ctrl_reg[`MIL_TIMER_ZERO_OVF_ENABLE];
  wire port_req = ctrl_reg[`MIL_PORT_CHANGE_FLAG] &
                  ctrl_reg[`MIL_PORT_CHANGE_ENABLE];
  // Wake ignores the global enable
  wire unmasked = ext_req | timer_zero_count_req | port_req | periph_any;
  wire gated    = unmasked & ctrl_reg[`MIL_GLOBAL_IRQ_ENABLE];

  // ****************************************************************
  // Service sequencer: sample at Q1, vector after two dummy cycles
  // ****************************************************************
  reg [1:0] service_count_reg;
  wire      service_idle = (service_count_reg == 2'h0);

  always @* begin
    service_start = at_q1 & service_idle & gated;
  end

  always @(posedge i_clock) begin
    if (i_reset) begin
      o_irq_request     <= 1'b0;
      o_wake            <= 1'b0;
      service_count_reg <= 2'h0;
      o_stack_push      <= 1'b0;
      o_stack_data      <= {PC_WIDTH{1'b0}};
      o_vector_load     <= 1'b0;
      o_vector_addr     <= `MIL_IRQ_VECTOR;
    end else begin
      o_stack_push  <= 1'b0;
      o_vector_load <= 1'b0;
      o_wake        <= unmasked;
      if (at_q1) begin
        o_irq_request <= gated;
        if (service_start) begin
          // Only the return address is kept; W and status are not
          o_stack_data      <= i_return_pc;
          service_count_reg <= `MIL_SERVICE_CYCLES;
        end else if (!service_idle) begin
          service_count_reg <= service_count_reg - 2'h1;
          if (service_count_reg == 2'h1) begin
            o_stack_push  <= 1'b1;
            o_vector_load <= 1'b1;
            o_vector_addr <= `MIL_IRQ_VECTOR;
          end
        end
      end
    end
  end

  // ****************************************************************
  // Wishbone read path and acknowledge
  // ****************************************************************
  always @* begin
    rdata_next = 32'h0000_0000;
    case (i_wb_adr)
      `MIL_IDX_CTRL_LO,
      `MIL_IDX_CTRL_HI:         rdata_next[7:0] = ctrl_reg;
      `MIL_IDX_PERIPH_FLAGS:    rdata_next[7:0] = periph_flags_reg;
      `MIL_IDX_PERIPH_ENABLES:  rdata_next[7:0] = periph_enables_reg;
      `MIL_IDX_TIMER_OPTION:    rdata_next[7:0] = o_timer_option;
      `MIL_IDX_PIN_SELECT:
        rdata_next[PORT_WIDTH-1:0] = pin_select_reg;
      `MIL_IDX_CORE_STATUS:
        rdata_next[3:0] = {o_wake, o_irq_request, service_count_reg};
      default:                  rdata_next = 32'h0000_0000;
    endcase
  end

  // Unmapped addresses are acknowledged with zero data, writes dropped
  always @(posedge i_clock) begin
    if (i_reset) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg   <= bus_req;
      rdata_reg <= bus_req ? rdata_next : 32'h0000_0000;
    end
  end

  assign o_wb_ack = ack_reg;
  assign o_wb_dat = rdata_reg;

endmodule // mil_interrupt_logic

// ===== mil_interrupt_logic_test.sv
// Self-checking bench for the interrupt request logic
`timescale 1ns/1ps
module mil_interrupt_logic_test;
  logic        i_clock, i_reset, cyc, stb, we, pin;
  logic [7:0]  adr, rd;
  logic [31:0] wdat;
  logic [5:0]  port, evt;
  wire  [31:0] o_wb_dat;
  wire         ack, rfi, irq, wake, push, vld;
  wire  [12:0] rpc, sdat, vaddr;
  wire  [1:0]  qph;
  wire  [7:0]  opt;
  int          error_cnt, n_tests, cyc_cnt;

  mil_interrupt_logic mil_interrupt_logic_inst (.i_clock(i_clock),
    .i_reset(i_reset), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(o_wb_dat),
    .o_wb_ack(ack), .i_external_irq_pin(pin), .i_port_pins(port),
    .i_timer_zero_rollover(evt[0]), .i_conversion_done(evt[1]),
    .i_data_write_done(evt[2]), .i_comparator_change(evt[3]),
    .i_timer_one_ovf(evt[4]), .i_port_read(evt[5]),
    .i_return_from_irq_instr(rfi), .i_return_pc(rpc),
    .o_quarter_phase(qph), .o_irq_request(irq), .o_wake(wake),
    .o_stack_push(push), .o_stack_data(sdat), .o_vector_load(vld),
    .o_vector_addr(vaddr), .o_timer_option(opt));
  mil_core_model mil_core_model_inst (.i_clock(i_clock), .i_reset(i_reset),
    .i_vector_load(vld), .o_return_from_irq_instr(rfi), .o_return_pc(rpc));

  // ****
  // Shared tasks
  // ****
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [12:0] e, logic [12:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic w(int n);
    repeat (n) @(posedge i_clock);
  endtask
  task automatic wb(logic wr, logic [7:0] a, logic [7:0] d);
    {cyc, stb, we, adr, wdat} <= {2'b11, wr, a, 24'h0, d};
    @(posedge i_clock);
    // Waits for the acknowledge; the hang guard ends a wait that never sees one
    while (ack !== 1'b1) begin
      @(posedge i_clock);
    end
    rd = o_wb_dat[7:0];
    {cyc, stb} <= 2'b00;
    @(posedge i_clock);
  endtask
  task automatic rc(logic [7:0] a, logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk($sformatf("reg_%h", a), {5'h0, e}, {5'h0, rd});
  endtask
  task automatic ev(int i);
    evt[i] <= 1'b1;
    @(posedge i_clock);
    evt <= 6'h00;
    w(2);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_regs();
    rc(8'h0B, 8'h00);
    rc(8'h81, 8'hFF);
    wb(1'b1, 8'h0C, 8'hFF);
    rc(8'h0C, 8'hC9);
    wb(1'b1, 8'h8C, 8'hFF);
    rc(8'h8C, 8'hC9);
    wb(1'b1, 8'h0B, 8'h18);
    rc(8'h8B, 8'h18);
    rc(8'h55, 8'h00);
    wb(1'b1, 8'h0C, 8'h00);
    wb(1'b1, 8'h8C, 8'h00);
    wb(1'b1, 8'h0B, 8'h00);
  endtask
  task automatic t_flags();
    logic [7:0] m[5] = '{8'h04, 8'h40, 8'h80, 8'h08, 8'h01};
    for (int i = 0; i < 5; i++) begin
      ev(i);
      rc(i == 0 ? 8'h0B : 8'h0C, m[i]);
      wb(1'b1, i == 0 ? 8'h0B : 8'h0C, 8'h00);
    end
  endtask
  task automatic t_edge();
    logic [9:0] c[4] = '{10'h3FD, 10'h3FE, 10'h2FD, 10'h2FE};
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 8'h81, c[i][9:2]);
      chk("timer_option", {5'h0, c[i][9:2]}, {5'h0, opt});
      pin <= c[i][1];
      w(8);
      wb(1'b1, 8'h0B, 8'h00);
      pin <= c[i][0];
      w(12);
      rc(8'h0B, {6'h0, c[i][0] == c[i][8], 1'b0});
    end
    wb(1'b1, 8'h0B, 8'h00);
  endtask
  task automatic t_port();
    wb(1'b1, 8'h96, 8'h01);
    ev(5);
    port <= 6'h02;
    w(8);
    rc(8'h0B, 8'h00);
    port <= 6'h03;
    w(8);
    rc(8'h0B, 8'h01);
    ev(5);
    wb(1'b1, 8'h0B, 8'h00);
    wb(1'b1, 8'h96, 8'h00);
  endtask
  task automatic t_service();
    int n;
    wb(1'b1, 8'h0B, 8'hA0);
    ev(0);
    n = 0;
    while (vld !== 1'b1 && n < 24) begin
      @(posedge i_clock);
      n++;
    end
    chk("vector_seen", 13'h1, {12'h0, n < 24});
    chk("vector_addr", 13'h0004, vaddr);
    chk("stack_data", rpc, sdat);
    rc(8'h0B, 8'h24);
    wb(1'b1, 8'h0B, 8'h20);
    w(20);
    rc(8'h0B, 8'hA0);
    wb(1'b1, 8'h0B, 8'h80);
    ev(0);
    w(16);
    rc(8'h0B, 8'h84);
    wb(1'b1, 8'h0B, 8'h24);
    w(2);
    chk("wake", 13'h1, {12'h0, wake});
    wb(1'b1, 8'h0B, 8'h00);
    wb(1'b1, 8'h8C, 8'h40);
    ev(1);
    chk("wake", 13'h0, {12'h0, wake});
    wb(1'b1, 8'h0B, 8'h40);
    w(2);
    chk("wake", 13'h1, {12'h0, wake});
  endtask

  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  // Hang guard: whole run needs well under this many cycles
  always @(posedge i_clock) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 6000) begin
      error_cnt++;
      $display("mismatch run_cycles expected below 6000 seen %0d", cyc_cnt);
      report_and_stop();
    end
  end
  initial begin
    {error_cnt, n_tests, cyc_cnt} = '0;
    {cyc, stb, we, adr, wdat, pin, port, evt} = '0;
    i_reset = 1'b1;
    repeat (4) @(posedge i_clock);
    i_reset <= 1'b0;
    @(posedge i_clock);
    t_regs();
    t_flags();
    t_edge();
    t_port();
    t_service();
    report_and_stop();
  end
endmodule // mil_interrupt_logic_test

bind mil_interrupt_logic mil_checker #(.PC_WIDTH(PC_WIDTH)) mil_checker_inst (
  .i_clock(i_clock), .i_reset(i_reset), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
  .o_quarter_phase(o_quarter_phase), .o_irq_request(o_irq_request),
  .o_stack_push(o_stack_push), .o_vector_load(o_vector_load),
  .o_vector_addr(o_vector_addr), .o_timer_option(o_timer_option));
